// File: hw/subtract_skip_bit_ops_exec.sv
// Purpose: execute rotate, subtract, skip, set and nibble-exchange operations
// Assumes: decode supplies operand byte and immediate; core owns memory and pc
// Notes: one-cycle latency; results registered, flags held in this block
`timescale 1ns/1ns
module subtract_skip_bit_ops_exec (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// request from decode
	input wire exec_pkg::request_t request_i,
	// current work register value held by the core
	input wire logic [7:0] work_i,
	// results
	output exec_pkg::result_t result_o,
	output exec_pkg::flags_t flags_o
);
	import exec_pkg::*;

	typedef struct packed {
		result_t res;
		flags_t flags;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// ----------------------------------------
	// subtract core
	// ----------------------------------------
	logic sub_sel;
	logic sub_borrow_form;
	logic [7:0] sub_rhs;
	logic borrow_in;
	logic [8:0] diff_full;
	logic [4:0] diff_low;
	logic [7:0] diff;
	logic [7:0] bit_mask;
	logic [7:0] mem_dec;
	logic [7:0] mem_inc;
	logic [7:0] swapped;
	logic bit_val;

	always_comb begin
		sub_borrow_form = (request_i.op == OP_SUBTRACT_WITH_BORROW)
			|| (request_i.op == OP_SUBTRACT_WITH_BORROW_IMM)
			|| (request_i.op == OP_BORROW_MINUS_TO_MEMORY);
		sub_sel = sub_borrow_form || (request_i.op == OP_SUBTRACT)
			|| (request_i.op == OP_SUBTRACT_IMM) || (request_i.op == OP_MINUS_TO_MEMORY);
		sub_rhs = ((request_i.op == OP_SUBTRACT_IMM)
			|| (request_i.op == OP_SUBTRACT_WITH_BORROW_IMM)) ? request_i.imm
			: request_i.mem_data;
		// borrow is the inverse of carry
		borrow_in = sub_borrow_form & ~state_reg.flags.carry;
		diff_full = {1'h0, work_i} - {1'h0, sub_rhs} - {8'h00, borrow_in};
		diff_low = {1'h0, work_i[3:0]} - {1'h0, sub_rhs[3:0]} - {4'h0, borrow_in};
		diff = diff_full[7:0];
		mem_dec = request_i.mem_data - BYTE_ONE;
		mem_inc = request_i.mem_data + BYTE_ONE;
		swapped = {request_i.mem_data[3:0], request_i.mem_data[7:4]};
	end

	// ----------------------------------------
	// per-bit select for the bit forms
	// ----------------------------------------
	// one-hot decode instead of a shift, so each bit keeps its own small cone
	logic [7:0] bit_pick;

	for (genvar g = 0; g < DATA_W; g++) begin : g_bit
		assign bit_mask[g] = (request_i.bit_sel == 3'(g));
		assign bit_pick[g] = bit_mask[g] & request_i.mem_data[g];
	end

	assign bit_val = |bit_pick;

	// ----------------------------------------
	// subtract flags
	// ----------------------------------------
	// worked out beside the adder so the next-state case stays a plain table
	flags_t sub_flags;
	logic diff_is_zero;
	logic operand_sign_differs;
	logic result_sign_moved;

	always_comb begin
		diff_is_zero = (diff == BYTE_ZERO);
		operand_sign_differs = (work_i[SIGN_BIT] != sub_rhs[SIGN_BIT]);
		result_sign_moved = (diff[SIGN_BIT] != work_i[SIGN_BIT]);
		// carry set means no borrow out of the top bit
		sub_flags.carry = ~diff_full[DATA_W];
		sub_flags.zero = diff_is_zero;
		// borrow-in counts against the low nibble as well
		sub_flags.nibble_carry_flag = ~diff_low[NIBBLE_TOP + 1];
		sub_flags.signed_wrap_flag = operand_sign_differs && result_sign_moved;
		// true sign of the wide result, not bit 7 of the stored byte
		sub_flags.signed_result_flag = diff[SIGN_BIT] ^ sub_flags.signed_wrap_flag;
		// borrow chains keep an earlier nonzero byte visible
		sub_flags.chained_zero_flag = sub_borrow_form
			? (state_reg.flags.chained_zero_flag && diff_is_zero)
			: diff_is_zero;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.res = '0;
		state_next.res.done = request_i.valid;
		state_next.res.cycles = SKIP_PLAIN_CYCLES;
		if (request_i.valid) begin
			case (request_i.op)
				OP_ROTATE_RIGHT_CARRY_TO_WORK: begin
					// memory untouched, only carry changes
					state_next.res.work_we = 1'b1;
					state_next.res.work_next = {state_reg.flags.carry,
						request_i.mem_data[7:1]};
					state_next.flags.carry = request_i.mem_data[0];
				end
				OP_SUBTRACT, OP_SUBTRACT_IMM, OP_SUBTRACT_WITH_BORROW,
				OP_SUBTRACT_WITH_BORROW_IMM: begin
					state_next.res.work_we = 1'b1;
					state_next.res.work_next = diff;
				end
				OP_MINUS_TO_MEMORY, OP_BORROW_MINUS_TO_MEMORY: begin
					state_next.res.mem_we = 1'b1;
					state_next.res.mem_wdata = diff;
				end
				OP_DECREMENT_SKIP_ZERO: begin
					state_next.res.mem_we = 1'b1;
					state_next.res.mem_wdata = mem_dec;
					state_next.res.skip = (mem_dec == BYTE_ZERO);
				end
				OP_DECREMENT_SKIP_TO_WORK: begin
					state_next.res.work_we = 1'b1;
					state_next.res.work_next = mem_dec;
					state_next.res.skip = (mem_dec == BYTE_ZERO);
				end
				OP_INCREMENT_SKIP_ZERO: begin
					state_next.res.mem_we = 1'b1;
					state_next.res.mem_wdata = mem_inc;
					state_next.res.skip = (mem_inc == BYTE_ZERO);
				end
				OP_INCREMENT_SKIP_TO_WORK: begin
					state_next.res.work_we = 1'b1;
					state_next.res.work_next = mem_inc;
					state_next.res.skip = (mem_inc == BYTE_ZERO);
				end
				OP_SKIP_NONZERO: begin
					state_next.res.skip = (request_i.mem_data != BYTE_ZERO);
				end
				OP_SKIP_NONZERO_BIT: begin
					state_next.res.skip = bit_val;
				end
				OP_SKIP_ON_ZERO: begin
					state_next.res.skip = (request_i.mem_data == BYTE_ZERO);
				end
				OP_SKIP_ON_ZERO_BIT: begin
					state_next.res.skip = ~bit_val;
				end
				OP_COPY_SKIP_ZERO: begin
					state_next.res.work_we = 1'b1;
					state_next.res.work_next = request_i.mem_data;
					state_next.res.skip = (request_i.mem_data == BYTE_ZERO);
				end
				OP_SET_BYTE: begin
					state_next.res.mem_we = 1'b1;
					state_next.res.mem_wdata = BYTE_ALL_ONES;
				end
				OP_SET_BIT: begin
					state_next.res.mem_we = 1'b1;
					state_next.res.mem_wdata = request_i.mem_data | bit_mask;
				end
				OP_NIBBLE_EXCHANGE: begin
					state_next.res.mem_we = 1'b1;
					state_next.res.mem_wdata = swapped;
				end
				OP_NIBBLE_EXCHANGE_TO_WORK: begin
					state_next.res.work_we = 1'b1;
					state_next.res.work_next = swapped;
				end
				default: begin
					state_next.res.done = 1'b1;
				end
			endcase
			if (sub_sel) begin
				// all six flags follow each subtract
				state_next.res.flags_we = 1'h1;
				state_next.flags = sub_flags;
			end
			if (request_i.op == OP_ROTATE_RIGHT_CARRY_TO_WORK) begin
				state_next.res.flags_we = 1'b1;
			end
			if (state_next.res.skip) begin
				state_next.res.cycles = SKIP_TAKEN_CYCLES;
			end
		end else begin
			state_next.res.done = 1'b0;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= '{res: '0, flags: FLAGS_RESET};
		end else begin
			state_reg <= state_next;
		end
	end

	assign result_o = state_reg.res;
	assign flags_o = state_reg.flags;
endmodule

// File: hw/exec_pkg.sv
// Purpose: shared types and constants for the subtract/skip/bit execution slice
// Assumes: 8-bit data path, one operation per request
// Notes: flag word is a packed struct, one bit per status flag
package exec_pkg;
	localparam int DATA_W = 8;
	localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam int SIGN_BIT = 7;
	localparam int NIBBLE_TOP = 3;
	// cycles for a taken skip (one execute plus one dummy fetch)
	localparam logic [1:0] SKIP_TAKEN_CYCLES = 2'h2;
	localparam logic [1:0] SKIP_PLAIN_CYCLES = 2'h1;

	typedef enum logic [4:0] {
		OP_NONE,
		OP_ROTATE_RIGHT_CARRY_TO_WORK,
		OP_SUBTRACT,
		OP_SUBTRACT_IMM,
		OP_MINUS_TO_MEMORY,
		OP_SUBTRACT_WITH_BORROW,
		OP_SUBTRACT_WITH_BORROW_IMM,
		OP_BORROW_MINUS_TO_MEMORY,
		OP_DECREMENT_SKIP_ZERO,
		OP_DECREMENT_SKIP_TO_WORK,
		OP_INCREMENT_SKIP_ZERO,
		OP_INCREMENT_SKIP_TO_WORK,
		OP_SKIP_NONZERO,
		OP_SKIP_NONZERO_BIT,
		OP_SKIP_ON_ZERO,
		OP_SKIP_ON_ZERO_BIT,
		OP_COPY_SKIP_ZERO,
		OP_SET_BYTE,
		OP_SET_BIT,
		OP_NIBBLE_EXCHANGE,
		OP_NIBBLE_EXCHANGE_TO_WORK
	} op_t;

	typedef struct packed {
		logic signed_wrap_flag;
		logic zero;
		logic nibble_carry_flag;
		logic carry;
		logic signed_result_flag;
		logic chained_zero_flag;
	} flags_t;

	localparam flags_t FLAGS_RESET = '0;

	typedef struct packed {
		logic valid;
		op_t op;
		logic [7:0] mem_data;
		logic [7:0] imm;
		logic [2:0] bit_sel;
	} request_t;

	typedef struct packed {
		logic done;
		logic mem_we;
		logic [7:0] mem_wdata;
		logic work_we;
		logic [7:0] work_next;
		logic flags_we;
		logic skip;
		logic [1:0] cycles;
	} result_t;
endpackage

// File: test/exec_monitor.sv
// Purpose: port-level checks for the execution slice
// Assumes: one-cycle registered answer per request
// Notes: last request is copied so checks line up with the answer
`timescale 1ns/1ns
module exec_monitor (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// inputs under watch
	input wire exec_pkg::request_t request_i,
	input wire logic [7:0] work_i,
	// outputs under watch
	input wire exec_pkg::result_t result_o,
	input wire exec_pkg::flags_t flags_o
);
	import exec_pkg::*;
	request_t req_reg;
	logic [7:0] work_reg;
	logic [7:0] m;
	assign m = req_reg.mem_data;
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			req_reg <= '0;
			work_reg <= 8'h00;
		end else begin
			req_reg <= request_i;
			work_reg <= work_i;
		end
	end
	function automatic logic is(input op_t o);
		return req_reg.valid && req_reg.op == o;
	endfunction
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	a_skip_cycles: assert property (result_o.skip |-> result_o.cycles == 2'h2)
		else $error("taken skip not two cycles");
	a_plain_cycles: assert property (result_o.done && !result_o.skip |-> result_o.cycles == 2'h1)
		else $error("plain op not one cycle");
	a_flags_held: assert property (!result_o.flags_we |-> $stable(flags_o))
		else $error("flags moved without update");
	a_set_byte_ones: assert property (is(OP_SET_BYTE) |-> result_o.mem_we && result_o.mem_wdata == 8'hFF)
		else $error("set byte wrong");
	a_dec_skip: assert property (is(OP_DECREMENT_SKIP_ZERO) |-> result_o.skip == (m == 8'h01))
		else $error("decrement skip wrong");
	a_inc_work: assert property (is(OP_INCREMENT_SKIP_TO_WORK) |-> result_o.work_next == m + 8'h01)
		else $error("increment to work wrong");
	a_zero_test: assert property (is(OP_SKIP_ON_ZERO) |-> result_o.skip == (m == 8'h00))
		else $error("zero test wrong");
	a_bit_zero: assert property (is(OP_SKIP_ON_ZERO_BIT) |-> result_o.skip == !m[req_reg.bit_sel])
		else $error("bit zero test wrong");
	a_sub_carry: assert property (is(OP_SUBTRACT) |-> flags_o.carry == (work_reg >= m))
		else $error("subtract carry wrong");
	c_skip: cover property (result_o.skip);
	c_borrow: cover property (result_o.flags_we && !flags_o.carry);
	c_mem_write: cover property (result_o.mem_we);
endmodule
bind subtract_skip_bit_ops_exec exec_monitor i_exec_monitor (
	.clock_i(clock_i), .reset_i(reset_i), .request_i(request_i),
	.work_i(work_i), .result_o(result_o), .flags_o(flags_o)
);

// File: test/subtract_skip_bit_ops_exec_tb.sv
// Purpose: directed bench for the execution slice
// Assumes: inputs change on falling edges, one request per cycle
// Notes: flags compared as {wrap, zero, nibble, carry, sign, chained}
`timescale 1ns/1ns
module subtract_skip_bit_ops_exec_tb;
	import exec_pkg::*;
	typedef struct packed {
		op_t o;
		logic [7:0] m;
		logic [2:0] b;
		logic [1:0] we;
		logic [7:0] d;
		logic s;
	} vec_t;
	logic clock_i = 1'h0;
	logic reset_i = 1'h1;
	request_t request_i = '0;
	logic [7:0] work_i = 8'h00;
	result_t result_o;
	flags_t flags_o;
	flags_t held;
	int n_errors = 0;
	int n_compared = 0;
	vec_t v[15] = '{
		'{OP_DECREMENT_SKIP_ZERO, 8'h01, 3'h0, 2'h2, 8'h00, 1'h1},
		'{OP_DECREMENT_SKIP_ZERO, 8'h00, 3'h0, 2'h2, 8'hFF, 1'h0},
		'{OP_DECREMENT_SKIP_TO_WORK, 8'h01, 3'h0, 2'h1, 8'h00, 1'h1},
		'{OP_INCREMENT_SKIP_ZERO, 8'hFF, 3'h0, 2'h2, 8'h00, 1'h1},
		'{OP_INCREMENT_SKIP_TO_WORK, 8'h05, 3'h0, 2'h1, 8'h06, 1'h0},
		'{OP_SKIP_NONZERO, 8'h00, 3'h0, 2'h0, 8'h00, 1'h0},
		'{OP_SKIP_NONZERO_BIT, 8'h10, 3'h4, 2'h0, 8'h00, 1'h1},
		'{OP_SKIP_NONZERO_BIT, 8'hEF, 3'h4, 2'h0, 8'h00, 1'h0},
		'{OP_SKIP_ON_ZERO, 8'h00, 3'h0, 2'h0, 8'h00, 1'h1},
		'{OP_SKIP_ON_ZERO_BIT, 8'hFE, 3'h1, 2'h0, 8'h00, 1'h0},
		'{OP_COPY_SKIP_ZERO, 8'h00, 3'h0, 2'h1, 8'h00, 1'h1},
		'{OP_SET_BYTE, 8'h12, 3'h0, 2'h2, 8'hFF, 1'h0},
		'{OP_SET_BIT, 8'h01, 3'h7, 2'h2, 8'h81, 1'h0},
		'{OP_NIBBLE_EXCHANGE, 8'hA5, 3'h0, 2'h2, 8'h5A, 1'h0},
		'{OP_NIBBLE_EXCHANGE_TO_WORK, 8'h3C, 3'h0, 2'h1, 8'hC3, 1'h0}
	};
	always #4 clock_i = ~clock_i;
	subtract_skip_bit_ops_exec i_subtract_skip_bit_ops_exec (
		.clock_i(clock_i), .reset_i(reset_i), .request_i(request_i),
		.work_i(work_i), .result_o(result_o), .flags_o(flags_o)
	);
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// valid stays up between calls, so requests run back to back
	task automatic run(input op_t o, input logic [7:0] m, i, w, input logic [2:0] b);
		request_i = '{1'h1, o, m, i, b};
		work_i = w;
		@(negedge clock_i);
	endtask
	task automatic tally_and_finish();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(negedge clock_i);
		reset_i = 1'h0;
		run(OP_SUBTRACT, 8'h03, 8'h00, 8'h05, 3'h0);
		chk(result_o.work_next, 8'h02);
		chk({6'h0, result_o.done, result_o.flags_we}, 8'h03);
		chk({2'h0, flags_o}, 8'h0C);
		run(OP_SUBTRACT_WITH_BORROW, 8'h05, 8'h00, 8'h03, 3'h0);
		chk(result_o.work_next, 8'hFE);
		chk({2'h0, flags_o}, 8'h02);
		run(OP_SUBTRACT_WITH_BORROW, 8'h01, 8'h00, 8'h10, 3'h0);
		chk(result_o.work_next, 8'h0E);
		chk({2'h0, flags_o}, 8'h04);
		run(OP_SUBTRACT_IMM, 8'h00, 8'h22, 8'h22, 3'h0);
		chk(result_o.work_next, 8'h00);
		chk({2'h0, flags_o}, 8'h1D);
		run(OP_BORROW_MINUS_TO_MEMORY, 8'h33, 8'h00, 8'h33, 3'h0);
		chk({6'h0, result_o.mem_we, result_o.work_we}, 8'h02);
		chk({2'h0, flags_o}, 8'h1D);
		run(OP_MINUS_TO_MEMORY, 8'h01, 8'h00, 8'h80, 3'h0);
		chk(result_o.mem_wdata, 8'h7F);
		chk({2'h0, flags_o}, 8'h26);
		run(OP_SUBTRACT_WITH_BORROW_IMM, 8'h00, 8'h20, 8'h50, 3'h0);
		chk(result_o.work_next, 8'h30);
		run(OP_ROTATE_RIGHT_CARRY_TO_WORK, 8'h02, 8'h00, 8'h00, 3'h0);
		chk(result_o.work_next, 8'h81);
		chk({6'h0, result_o.done, result_o.flags_we}, 8'h03);
		chk({2'h0, flags_o}, 8'h08);
		run(OP_ROTATE_RIGHT_CARRY_TO_WORK, 8'h01, 8'h00, 8'h00, 3'h0);
		chk({result_o.mem_we, flags_o.carry, result_o.work_next[7:2]}, 8'h40);
		held = flags_o;
		foreach (v[k]) begin
			run(v[k].o, v[k].m, 8'h00, 8'h00, v[k].b);
			chk({7'h0, result_o.skip}, {7'h0, v[k].s});
			chk({6'h0, result_o.cycles}, v[k].s ? 8'h02 : 8'h01);
			chk({6'h0, result_o.mem_we, result_o.work_we}, {6'h0, v[k].we});
			chk(result_o.mem_we ? result_o.mem_wdata :
				result_o.work_we ? result_o.work_next : 8'h00, v[k].d);
			chk({2'h0, flags_o}, {2'h0, held});
			chk({6'h0, result_o.done, result_o.flags_we}, 8'h02);
		end
		run(OP_NONE, 8'h55, 8'h00, 8'h00, 3'h0);
		chk({3'h0, result_o.done, result_o.mem_we, result_o.work_we, result_o.flags_we,
			result_o.skip}, 8'h10);
		chk({6'h0, result_o.cycles}, 8'h01);
		request_i = '0;
		@(negedge clock_i);
		chk({4'h0, result_o.done, result_o.mem_we, result_o.work_we, result_o.skip},
			8'h00);
		reset_i = 1'h1;
		@(negedge clock_i);
		chk({2'h0, flags_o}, 8'h00);
		reset_i = 1'h0;
		@(negedge clock_i);
		tally_and_finish();
	end
	initial begin
		#20000;
		n_errors++;
		tally_and_finish();
	end
endmodule
